// *** hw/ssl_ctrl.sv ***
// Behaviour
// R1: Writing one to bit 7 starts both buck ramps; zero changes nothing.
// R2: The trigger bit clears itself when both bucks reach their targets.
// R3: With bypass bit 6 set, set-point updates start ramps without trigger.
// R4: Ramp code selects 160 to 2.5 us per step; code 7 is immediate.
// R5: Ramp register at 0x1A, resets to 0x06.
// R6: Ramp code affects only the two bucks, never the linear regulator.
// R7: Software clears pulse-frequency mode before tight-mode buck lowering.
// R8: Linear regulator register at 0x1B, 6-bit code, top bits zero, reset 1Fh.
// R9: Linear regulator code maps to 900 mV plus 25 mV per code.
// R10: Each accepted linear regulator write blanks its voltage monitors for 5 ms.
// R11: Linear regulator writes are accepted only while the password unlocks.
// R12: Reserved bits read zero and ignore writes.
// R13: The 25 mV mapping holds up to code 3Fh.
`timescale 1ns/1ps
module ssl_ctrl
    import ssl_pkg::*;
#(
    parameter int              SP_W      = 6,
    parameter logic [SP_W-1:0] LVL_RST   = '0,
    parameter int              BLANK_CNT = BLANK_CYC
)
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    input  wire logic              pw_unlock,
    input  wire logic [SP_W-1:0]   buck_one_setpoint,
    input  wire logic [SP_W-1:0]   buck_two_setpoint,
    input  wire logic              setpoint_update,
    output logic [SP_W-1:0]        buck_one_level,
    output logic [SP_W-1:0]        buck_two_level,
    output logic                   ramp_busy,
    output logic [LDO_W-1:0]       linear_reg_one_code,
    output logic [MV_W-1:0]        linear_reg_one_mv,
    output logic                   monitor_blank
);
    import ssl_pkg::*;

    // ==========================================================
    // Register state
    // ==========================================================
    logic                go_q, go_d;
    logic                byp_q;
    logic [RATE_W-1:0]   rate_q;
    logic [LDO_W-1:0]    ldo_q;
    logic [MV_W-1:0]     mv_q;
    logic [7:0]          rdata_q, rdata_d;
    logic [31:0]         blank_q, blank_d;
    ssl_state_t          state_q, state_d;
    logic [SP_W-1:0]     tgt1_q, tgt2_q, lvl1_q, lvl2_q, lvl1_d, lvl2_d;

    // ==========================================================
    // Decode
    // ==========================================================
    wire ramp_sel  = (reg_addr == RAMP_OFS);
    wire ldo_sel   = (reg_addr == LDO_OFS);
    wire ramp_wr   = reg_wr && ramp_sel;
    wire ldo_wr    = reg_wr && ldo_sel;
    wire ldo_take  = ldo_wr && pw_unlock;
    wire go_write  = ramp_wr && reg_wdata[GO_BIT];
    wire byp_start = byp_q && setpoint_update;
    wire launch    = go_write || byp_start;
    wire ramping   = (state_q == SSL_RAMP);
    wire immediate = (rate_q == RATE_IMM);
    wire at_target = (lvl1_q == tgt1_q) && (lvl2_q == tgt2_q);
    wire done      = ramping && at_target && !launch;
    wire tick;
    // A trigger written together with a new code must step at the new
    // rate, so the first step length is taken from the write data.
    wire [RATE_W-1:0] rate_now  = ramp_wr ? reg_wdata[RATE_W-1:0] : rate_q;
    wire [TMR_W-1:0]  step_len  = step_cycles(rate_now);

    function automatic logic [SP_W-1:0] toward(
        input logic [SP_W-1:0] cur,
        input logic [SP_W-1:0] tgt
    );
        if (cur < tgt)
            return cur + SP_W'(1);
        else if (cur > tgt)
            return cur - SP_W'(1);
        return cur;
    endfunction : toward

    // R6: bucks only
    ssl_step_timer u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (launch),
        .run      (ramping && !immediate),
        .load_val (step_len),
        .tick     (tick)
    );

    // ==========================================================
    // Ramp engine
    // ==========================================================
    // R1: trigger set wins
    assign go_d = go_write ? 1'b1 : (done ? 1'b0 : go_q);
    // R3: bypass launch
    assign state_d = launch ? SSL_RAMP : (done ? SSL_IDLE : state_q);
    // R4: step or jump
    assign lvl1_d = !ramping ? lvl1_q : immediate ? tgt1_q :
                    tick ? toward(lvl1_q, tgt1_q) : lvl1_q;
    assign lvl2_d = !ramping ? lvl2_q : immediate ? tgt2_q :
                    tick ? toward(lvl2_q, tgt2_q) : lvl2_q;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_q <= SSL_IDLE;
            go_q    <= RAMP_RST[GO_BIT];
            lvl1_q  <= LVL_RST;
            lvl2_q  <= LVL_RST;
            tgt1_q  <= LVL_RST;
            tgt2_q  <= LVL_RST;
        end
        else
        begin
            state_q <= state_d;
            // R2: self clear
            go_q    <= go_d;
            lvl1_q  <= lvl1_d;
            lvl2_q  <= lvl2_d;
            if (launch)
            begin
                tgt1_q <= buck_one_setpoint;
                tgt2_q <= buck_two_setpoint;
            end
        end
    end

    // ==========================================================
    // Register writes and blanking
    // ==========================================================
    // R10: blank reload
    assign blank_d = ldo_take ? 32'(BLANK_CNT) :
                     (blank_q != 32'h0) ? blank_q - 32'h1 : blank_q;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            // R5: ramp reset value
            byp_q   <= RAMP_RST[BYP_BIT];
            rate_q  <= RAMP_RST[RATE_W-1:0];
            // R8: set-point reset
            ldo_q   <= LDO_RST[LDO_W-1:0];
            mv_q    <= ldo_millivolts(LDO_RST[LDO_W-1:0]);
            blank_q <= 32'h0;
            rdata_q <= 8'h00;
        end
        else
        begin
            if (ramp_wr)
            begin
                byp_q  <= reg_wdata[BYP_BIT];
                rate_q <= reg_wdata[RATE_W-1:0];
            end
            // R11: password gate
            if (ldo_take)
                ldo_q <= reg_wdata[LDO_W-1:0];
            // R9: voltage map
            mv_q    <= ldo_millivolts(ldo_take ? reg_wdata[LDO_W-1:0]
                                               : ldo_q);
            blank_q <= blank_d;
            if (reg_rd)
                rdata_q <= rdata_d;
        end
    end

    // R12: reserved read zero
    assign rdata_d = ramp_sel ? {go_q, byp_q, 3'h0, rate_q} :
                     ldo_sel  ? {2'h0, ldo_q} : 8'h00;

    assign reg_rdata           = rdata_q;
    assign buck_one_level      = lvl1_q;
    assign buck_two_level      = lvl2_q;
    assign ramp_busy           = ramping;
    assign linear_reg_one_code = ldo_q;
    assign linear_reg_one_mv   = mv_q;
    assign monitor_blank       = (blank_q != 32'h0);

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_go_set;
        go_write |=> go_q && ramp_busy;
    endproperty
    a_go_set: assert property (p_go_set) // R1
        else $error("trigger write did not start a ramp");

    property p_go_zero;
        ramp_wr && !reg_wdata[GO_BIT] && !done |=> go_q == $past(go_q);
    endproperty
    a_go_zero: assert property (p_go_zero) // R1
        else $error("writing zero to trigger changed it");

    property p_go_clr;
        done && !go_write |=> !go_q && !ramp_busy;
    endproperty
    a_go_clr: assert property (p_go_clr) // R2
        else $error("trigger not cleared at end of ramp");

    property p_byp;
        byp_start |=> ramp_busy && tgt1_q == $past(buck_one_setpoint);
    endproperty
    a_byp: assert property (p_byp) // R3
        else $error("bypass update did not launch ramp");

    property p_nobyp;
        !byp_q && !go_write && !ramping |=> !ramp_busy;
    endproperty
    a_nobyp: assert property (p_nobyp) // R3
        else $error("ramp started without trigger");

    property p_imm;
        ramping && immediate && !launch |=> lvl1_q == $past(tgt1_q)
                                          && lvl2_q == $past(tgt2_q);
    endproperty
    a_imm: assert property (p_imm) // R4
        else $error("immediate code did not jump");

    property p_step;
        tick && !launch && $stable(rate_q) && rate_q == 3'h6
            |=> !tick [*8];
    endproperty
    a_step: assert property (p_step) // R4
        else $error("step spacing too short");

    property p_ldo_iso;
        ramp_wr && !ldo_take |=> $stable(ldo_q);
    endproperty
    a_ldo_iso: assert property (p_ldo_iso) // R6
        else $error("ramp write disturbed regulator code");

    property p_ldo_rd;
        reg_rd && ldo_sel |=> reg_rdata[7:6] == 2'h0
                              && reg_rdata[5:0] == $past(ldo_q);
    endproperty
    a_ldo_rd: assert property (p_ldo_rd) // R8
        else $error("regulator read value wrong");

    property p_mv;
        ##1 linear_reg_one_mv == LDO_BASE_MV + MV_W'(ldo_q) * LDO_STEP_MV;
    endproperty
    a_mv: assert property (p_mv) // R9
        else $error("regulator millivolt value wrong");

    property p_blank;
        ldo_take |=> monitor_blank && blank_q == 32'(BLANK_CNT);
    endproperty
    a_blank: assert property (p_blank) // R10
        else $error("monitor blanking not started");

    property p_pw;
        ldo_wr && !pw_unlock |=> $stable(ldo_q) && blank_q != 32'(BLANK_CNT);
    endproperty
    a_pw: assert property (p_pw) // R11
        else $error("locked regulator write accepted");

    property p_ramp_rd;
        reg_rd && ramp_sel |=> reg_rdata[5:3] == 3'h0;
    endproperty
    a_ramp_rd: assert property (p_ramp_rd) // R12
        else $error("reserved ramp bits not zero");

    property p_ramp_end;
        go_write ##[1:1000] !go_q;
    endproperty
    cv_ramp_end: cover property (p_ramp_end);
    cv_byp: cover property (byp_start);
    cv_blank: cover property (ldo_take ##1 monitor_blank);
    cv_locked: cover property (ldo_wr && !pw_unlock);
endmodule : ssl_ctrl

// *** hw/ssl_pkg.sv ***
package ssl_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_NS      = 100;
    // Step times per ramp code, in nanoseconds (160 us down to 2.5 us).
    localparam int STEP_NS_0   = 160000;
    localparam int STEP_NS_1   = 80000;
    localparam int STEP_NS_2   = 40000;
    localparam int STEP_NS_3   = 20000;
    localparam int STEP_NS_4   = 10000;
    localparam int STEP_NS_5   = 5000;
    localparam int STEP_NS_6   = 2500;
    localparam int BLANK_US    = 5000;
    localparam int BLANK_CYC   = (BLANK_US * 1000) / CLK_NS;
    localparam int TMR_W       = 16;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] RAMP_OFS  = 8'h1a;
    localparam logic [7:0] LDO_OFS   = 8'h1b;
    localparam logic [7:0] RAMP_RST  = 8'h06;
    localparam logic [7:0] LDO_RST   = 8'h1f;
    localparam int         GO_BIT    = 7;
    localparam int         BYP_BIT   = 6;
    localparam int         RATE_W    = 3;
    localparam int         LDO_W     = 6;
    localparam logic [2:0] RATE_IMM  = 3'h7;

    // ==========================================================
    // Linear regulator voltage mapping
    // ==========================================================
    localparam int         MV_W        = 12;
    localparam logic [11:0] LDO_BASE_MV = 12'h384;
    localparam logic [11:0] LDO_STEP_MV = 12'h019;

    typedef enum logic [1:0] {
        SSL_IDLE = 2'b01,
        SSL_RAMP = 2'b10
    } ssl_state_t;

    // Cycles per step; the shortest step is well above one cycle.
    function automatic logic [TMR_W-1:0] step_cycles(
        input logic [RATE_W-1:0] code
    );
        int ns;
        case (code)
            3'h0:    ns = STEP_NS_0;
            3'h1:    ns = STEP_NS_1;
            3'h2:    ns = STEP_NS_2;
            3'h3:    ns = STEP_NS_3;
            3'h4:    ns = STEP_NS_4;
            3'h5:    ns = STEP_NS_5;
            default: ns = STEP_NS_6;
        endcase
        return TMR_W'((ns + CLK_NS - 1) / CLK_NS);
    endfunction : step_cycles

    // R13: full code range
    function automatic logic [MV_W-1:0] ldo_millivolts(
        input logic [LDO_W-1:0] code
    );
        return LDO_BASE_MV + MV_W'(LDO_STEP_MV * MV_W'(code));
    endfunction : ldo_millivolts

endpackage : ssl_pkg

// *** hw/ssl_step_timer.sv ***
`timescale 1ns/1ps
module ssl_step_timer
    import ssl_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic             run,
    input  wire logic [TMR_W-1:0] load_val,
    output logic                  tick
);
    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;
    wire              at_one = (cnt_q == TMR_W'(1));

    // ==========================================================
    // Reload on start and on every tick, so a new rate takes
    // effect at the next step boundary.
    // ==========================================================
    assign tick  = run && !start && at_one;
    assign cnt_d = start ? load_val :
                   !run  ? cnt_q :
                   at_one ? load_val : cnt_q - TMR_W'(1);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule : ssl_step_timer

// *** bench/ssl_host.sv ***
`timescale 1ns/1ps
// ==========================================================
// Host software model driving the register bus
// ==========================================================
module ssl_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            pw_unlock,
    output logic [5:0]      buck_one_setpoint,
    output logic [5:0]      buck_two_setpoint,
    output logic            setpoint_update
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        pw_unlock = 1'b0;
        buck_one_setpoint = 6'h00;
        buck_two_setpoint = 6'h00;
        setpoint_update = 1'b0;
    end

    // Released write data is inverted so stale values never look valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic unlock(input logic u);
        @(posedge core_clk);
        pw_unlock <= u;
    endtask : unlock

    task automatic bucks(input logic [5:0] s, input logic pulse);
        @(posedge core_clk);
        buck_one_setpoint <= s;
        buck_two_setpoint <= s;
        setpoint_update <= pulse;
        @(posedge core_clk);
        setpoint_update <= 1'b0;
    endtask : bucks
endmodule : ssl_host

// *** bench/ssl_ctrl_tb.sv ***
`timescale 1ns/1ps
module ssl_ctrl_tb;
    import ssl_pkg::*;
    localparam int BLANK_T = 20;
    logic        core_clk, rst_n, reg_wr, reg_rd, pw_unlock, upd;
    logic        ramp_busy, monitor_blank;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
    logic [5:0]  sp1, sp2, lvl1, lvl2, code, tgt;
    logic [11:0] mv;
    int          n_errors, compares, seed, cnt, m_ldo, sc;

    ssl_ctrl #(.BLANK_CNT(BLANK_T)) ssl_ctrl_inst (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pw_unlock(pw_unlock),
        .buck_one_setpoint(sp1), .buck_two_setpoint(sp2),
        .setpoint_update(upd), .buck_one_level(lvl1),
        .buck_two_level(lvl2), .ramp_busy(ramp_busy),
        .linear_reg_one_code(code), .linear_reg_one_mv(mv),
        .monitor_blank(monitor_blank));

    ssl_host ssl_host_inst (
        .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .pw_unlock(pw_unlock), .buck_one_setpoint(sp1),
        .buck_two_setpoint(sp2), .setpoint_update(upd));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // Counts cycles until busy or blanking drops, bounded.
    task automatic run_out(input bit blank_sel);
        while ((blank_sel ? monitor_blank : ramp_busy) === 1'b1 && cnt < 4000)
        begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
    endtask : run_out

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial
    begin
        #(40000 * 100);
        n_errors++;
        print_verdict();
    end

    initial
    begin
        seed = 20;
        n_errors = 0;
        compares = 0;
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk(ramp_busy, 0);
        chk(mv, 1675);
        ssl_host_inst.rd(8'h1a, rv);
        chk(rv, 8'h06);
        ssl_host_inst.rd(8'h1b, rv);
        chk(rv, 8'h1f);
        ssl_host_inst.rd(8'h33, rv);
        chk(rv, 8'h00);
        ssl_host_inst.wr(8'h1b, 8'h05);
        #1 chk(monitor_blank, 0);
        ssl_host_inst.rd(8'h1b, rv);
        chk(rv, 8'h1f);
        ssl_host_inst.unlock(1'b1);
        ssl_host_inst.wr(8'h1b, 8'hff);
        #1 cnt = 0;
        run_out(1'b1);
        chk(cnt >= BLANK_T && cnt <= BLANK_T + 1, 1);
        chk(mv, 900 + 25 * 63);
        ssl_host_inst.rd(8'h1b, rv);
        chk(rv, 8'h3f);
        repeat (4)
        begin
            m_ldo = $random(seed) & 63;
            ssl_host_inst.wr(8'h1b, 8'(m_ldo));
            #1 chk(monitor_blank, 1);
            chk(mv, 900 + 25 * m_ldo);
            chk(code, m_ldo);
        end
        ssl_host_inst.wr(8'h1a, 8'h3f);
        ssl_host_inst.rd(8'h1a, rv);
        chk(rv, 8'h07);
        ssl_host_inst.bucks(6'h01, 1'b1);
        #1 chk(ramp_busy, 0);
        ssl_host_inst.wr(8'h1a, 8'h00);
        #1 chk(ramp_busy, 0);
        for (int r = 0; r < 8; r++)
        begin
            tgt = 6'(~r & 1);
            ssl_host_inst.bucks(tgt, 1'b0);
            ssl_host_inst.wr(8'h1a, 8'(8'h80 | r));
            #1 chk(ramp_busy, 1);
            cnt = 0;
            if (r < 7)
            begin
                ssl_host_inst.rd(8'h1a, rv);
                chk(rv, 8'(8'h80 | r));
                cnt = 2;
            end
            run_out(1'b0);
            sc = (r == 7) ? 0 : (160000 >> r) / 100;
            chk(cnt >= sc && cnt <= sc + 3, 1);
            chk(lvl1, tgt);
            chk(lvl2, tgt);
            ssl_host_inst.rd(8'h1a, rv);
            chk(rv, 8'(r));
            chk(code, m_ldo);
        end
        ssl_host_inst.wr(8'h1a, 8'h46);
        ssl_host_inst.bucks(6'h03, 1'b1);
        #1 chk(ramp_busy, 1);
        cnt = 0;
        run_out(1'b0);
        chk(cnt >= 75 && cnt <= 78, 1);
        chk(lvl1, 6'h03);
        ssl_host_inst.rd(8'h1a, rv);
        chk(rv, 8'h46);
        print_verdict();
    end
endmodule : ssl_ctrl_tb
